// [design/dcv_cfg.svh]
// constants for the dc link voltage supervisor
`ifndef DCV_CFG_SVH
`define DCV_CFG_SVH
`define DCV_CLK_NS 5
`define DCV_MS_NS 1000000
`define DCV_MS_CYCLES (`DCV_MS_NS / `DCV_CLK_NS)
`define DCV_RESTART_MAX_S 10
`define DCV_RESTART_MAX_MS (`DCV_RESTART_MAX_S * 1000)
`define DCV_OV_FAULT_V 11'h348
`define DCV_OV_CTRL_V 11'h30c
`define DCV_CHOP_ON_V 11'h30c
`define DCV_CHOP_OFF_V 11'h2f8
`define DCV_OV_WARN_V 11'h2e9
`define DCV_K_UV_WARN 11'h4cb
`define DCV_K_UV_CTRL 11'h43b
`define DCV_K_RLY_CLOSE 11'h466
`define DCV_K_RLY_OPEN 11'h41e
`define DCV_K_SHIFT 10
`define DCV_FC_NONE 16'h0000
`define DCV_FC_UV 16'h0c94
`define DCV_FC_OV 16'h0001
`endif

// [design/dcv_pkg.sv]
// types for the dc link voltage supervisor
package dcv_pkg;
  typedef logic [10:0] dcv_volt_t;
  typedef logic [9:0] dcv_ac_t;
  typedef enum logic [4:0] {
    DCV_RUN = 5'h01,
    DCV_RIDE = 5'h02,
    DCV_FAIL = 5'h04,
    DCV_CHARGE = 5'h08,
    DCV_TRIP = 5'h10
  } dcv_state_e;
endpackage : dcv_pkg

// [design/dcv_limits.sv]
// supply scaled undervoltage and charging relay limits
`timescale 1ns/1ps
`include "dcv_cfg.svh"
module dcv_limits (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // supply base
  input wire dcv_pkg::dcv_ac_t base_v,
  // limits
  output dcv_pkg::dcv_volt_t uv_warn_lim,
  output dcv_pkg::dcv_volt_t uv_ctrl_lim,
  output dcv_pkg::dcv_volt_t close_lim,
  output dcv_pkg::dcv_volt_t open_lim
);
  function automatic dcv_pkg::dcv_volt_t scale(input dcv_pkg::dcv_ac_t v,
                                               input logic [10:0] k);
    logic [20:0] p;
    p = {11'h000, v} * {10'h000, k};
    scale = p[20:`DCV_K_SHIFT];
  endfunction : scale

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      uv_warn_lim <= 11'h000;
      uv_ctrl_lim <= 11'h000;
      close_lim <= 11'h000;
      open_lim <= 11'h000;
    end
    else
    begin
      uv_warn_lim <= scale(base_v, `DCV_K_UV_WARN);
      uv_ctrl_lim <= scale(base_v, `DCV_K_UV_CTRL);
      close_lim <= scale(base_v, `DCV_K_RLY_CLOSE);
      open_lim <= scale(base_v, `DCV_K_RLY_OPEN);
    end
  end
endmodule : dcv_limits

// [design/dcv_sup.sv]
// dc link voltage supervisor: limits, ride-through and auto restart
`timescale 1ns/1ps
`include "dcv_cfg.svh"
module dcv_sup #(
  parameter int MS_CYCLES = `DCV_MS_CYCLES
) (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // link sample
  input wire dcv_pkg::dcv_volt_t link_voltage,
  input wire logic sample_valid,
  // drive state
  input wire logic start_cmd,
  input wire logic generating,
  input wire logic scalar_mode,
  input wire logic [15:0] decel_time,
  input wire logic fault_reset,
  // configuration
  input wire logic ovc_en,
  input wire logic uvc_en,
  input wire logic auto_restart_en,
  input wire logic force_restart_en,
  input wire logic vec_start_auto,
  input wire logic scalar_start_auto,
  input wire logic range_auto,
  input wire logic adaptive_en,
  input wire dcv_pkg::dcv_ac_t est_supply,
  input wire dcv_pkg::dcv_ac_t range_low,
  input wire logic [13:0] restart_time_ms,
  // readout and flags
  output dcv_pkg::dcv_volt_t link_voltage_readout,
  output logic ov_warn,
  output logic uv_warn,
  output logic restart_warn,
  output logic [15:0] fault_code,
  output logic tripped,
  // power stage control
  output logic gen_torque_limit,
  output logic decel_stretch,
  output logic [16:0] decel_time_eff,
  output logic chopper_on,
  output logic relay_closed,
  output logic modulation_en,
  output logic fan_en,
  output logic precharge_en,
  output logic ride_through,
  output logic standby,
  output logic flying_start_ok
);
  dcv_pkg::dcv_state_e st_q;
  dcv_pkg::dcv_state_e st_d;
  dcv_pkg::dcv_volt_t uv_warn_lim;
  dcv_pkg::dcv_volt_t uv_ctrl_lim;
  dcv_pkg::dcv_volt_t close_lim;
  dcv_pkg::dcv_volt_t open_lim;
  dcv_pkg::dcv_ac_t base_v;
  logic [17:0] ms_cnt_q;
  logic ms_tick;
  logic [13:0] rs_ms_q;
  logic [13:0] window;
  logic timeout;
  logic start_eff;
  logic [15:0] fc_d;
  dcv_pkg::dcv_volt_t v;

  assign base_v = (range_auto && adaptive_en) ? est_supply : range_low;

  dcv_limits u_limits (
    .mclk(mclk),
    .nrst(nrst),
    .base_v(base_v),
    .uv_warn_lim(uv_warn_lim),
    .uv_ctrl_lim(uv_ctrl_lim),
    .close_lim(close_lim),
    .open_lim(open_lim)
  );

  // raw link input steers each comparison except gen_torque_limit and decel_stretch, which use the readout
  assign v = link_voltage;

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      link_voltage_readout <= 11'h000;
    else if (sample_valid)
      link_voltage_readout <= link_voltage;
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      ov_warn <= 1'b0;
      uv_warn <= 1'b0;
    end
    else if (sample_valid)
    begin
      ov_warn <= (v >= `DCV_OV_WARN_V);
      uv_warn <= (v < uv_warn_lim);
    end
  end

  // chopper with hysteresis band
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      chopper_on <= 1'b0;
    else if (sample_valid)
    begin
      if (v >= `DCV_CHOP_ON_V)
        chopper_on <= 1'b1;
      else if (v < `DCV_CHOP_OFF_V)
        chopper_on <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      relay_closed <= 1'b0;
    else if (sample_valid)
    begin
      if (v > close_lim)
        relay_closed <= 1'b1;
      else if (v < open_lim)
        relay_closed <= 1'b0;
    end
  end

  assign gen_torque_limit = ovc_en && generating &&
                            (link_voltage_readout >= `DCV_OV_CTRL_V);
  assign decel_stretch = ovc_en && (link_voltage_readout >= `DCV_OV_CTRL_V);

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      decel_time_eff <= 17'h00000;
    else if (decel_stretch)
      decel_time_eff <= {1'b0, decel_time} + {2'b00, decel_time[15:1]};
    else
      decel_time_eff <= {1'b0, decel_time};
  end

  assign flying_start_ok = scalar_mode ? scalar_start_auto : vec_start_auto;

  // millisecond enable for the restart window
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      ms_cnt_q <= 18'h00000;
    else if (ms_tick || st_q != dcv_pkg::DCV_FAIL)
      ms_cnt_q <= 18'h00000;
    else
      ms_cnt_q <= ms_cnt_q + 18'h00001;
  end
  assign ms_tick = (ms_cnt_q == 18'(MS_CYCLES - 1));

  assign window = (restart_time_ms > 14'(`DCV_RESTART_MAX_MS)) ?
                  14'(`DCV_RESTART_MAX_MS) : restart_time_ms;
  assign timeout = (rs_ms_q >= window);

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      rs_ms_q <= 14'h0000;
    else if (st_q != dcv_pkg::DCV_FAIL)
      rs_ms_q <= 14'h0000;
    else if (ms_tick && !timeout)
      rs_ms_q <= rs_ms_q + 14'h0001;
  end

  assign start_eff = start_cmd || force_restart_en;

  always_comb
  begin
    st_d = st_q;
    fc_d = fault_code;
    unique case (st_q)
      dcv_pkg::DCV_RUN:
      begin
        if (sample_valid && v >= `DCV_OV_FAULT_V)
        begin
          st_d = dcv_pkg::DCV_TRIP;
          fc_d = `DCV_FC_OV;
        end
        else if (sample_valid && v < uv_ctrl_lim)
        begin
          if (uvc_en && flying_start_ok)
            st_d = dcv_pkg::DCV_RIDE;
          else if (auto_restart_en || force_restart_en)
            st_d = dcv_pkg::DCV_FAIL;
          else if (v < open_lim)
            st_d = dcv_pkg::DCV_CHARGE;
        end
      end
      dcv_pkg::DCV_RIDE:
      begin
        if (sample_valid && v >= uv_warn_lim)
          st_d = dcv_pkg::DCV_RUN;
        else if (sample_valid && v < open_lim)
          st_d = (auto_restart_en || force_restart_en) ?
                 dcv_pkg::DCV_FAIL : dcv_pkg::DCV_CHARGE;
      end
      dcv_pkg::DCV_FAIL:
      begin
        if (sample_valid && relay_closed && v > close_lim &&
            start_eff && flying_start_ok)
          st_d = dcv_pkg::DCV_RUN;
        else if (timeout && !force_restart_en)
        begin
          st_d = dcv_pkg::DCV_TRIP;
          fc_d = `DCV_FC_UV;
        end
      end
      dcv_pkg::DCV_CHARGE:
      begin
        if (sample_valid && relay_closed && v > close_lim)
          st_d = dcv_pkg::DCV_RUN;
      end
      dcv_pkg::DCV_TRIP:
      begin
        if (fault_reset)
        begin
          st_d = dcv_pkg::DCV_RUN;
          fc_d = `DCV_FC_NONE;
        end
      end
      default:
      begin
        st_d = dcv_pkg::DCV_TRIP;
        fc_d = `DCV_FC_NONE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_q <= dcv_pkg::DCV_RUN;
      fault_code <= `DCV_FC_NONE;
    end
    else
    begin
      st_q <= st_d;
      fault_code <= fc_d;
    end
  end

  assign tripped = (st_q == dcv_pkg::DCV_TRIP);
  assign restart_warn = (st_q == dcv_pkg::DCV_FAIL);
  assign ride_through = (st_q == dcv_pkg::DCV_RIDE);
  assign standby = (st_q == dcv_pkg::DCV_CHARGE);
  assign modulation_en = (st_q == dcv_pkg::DCV_RUN) ||
                         (st_q == dcv_pkg::DCV_RIDE);
  assign fan_en = modulation_en;
  assign precharge_en = (st_q == dcv_pkg::DCV_FAIL) ||
                        (st_q == dcv_pkg::DCV_CHARGE);

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);

  a_ov_fault_trip: assert property (
    sample_valid && link_voltage >= `DCV_OV_FAULT_V && st_q == dcv_pkg::DCV_RUN
    |=> tripped && fault_code == `DCV_FC_OV)
    else $error("overvoltage fault did not trip");

  a_chop_on: assert property (
    sample_valid && link_voltage >= `DCV_CHOP_ON_V |=> chopper_on)
    else $error("chopper not on at start limit");

  a_chop_hyst: assert property (
    chopper_on && sample_valid && link_voltage >= `DCV_CHOP_OFF_V |=> chopper_on)
    else $error("chopper dropped inside hysteresis band");

  a_gen_torque_cut: assert property (
    ovc_en && generating && $past(sample_valid) &&
    $past(link_voltage) >= `DCV_OV_CTRL_V |-> gen_torque_limit)
    else $error("generating torque not limited");

  a_decel_longer: assert property (
    decel_stretch && decel_time > 16'h0001
    |=> decel_time_eff > {1'b0, $past(decel_time)})
    else $error("deceleration not stretched");

  a_fail_outputs: assert property (
    restart_warn |-> !modulation_en && !fan_en && precharge_en && !tripped)
    else $error("supply failure outputs wrong");

  a_uv_trip_code: assert property (
    st_q == dcv_pkg::DCV_FAIL && timeout && !force_restart_en &&
    !(sample_valid && relay_closed && link_voltage > close_lim)
    |=> tripped && fault_code == `DCV_FC_UV)
    else $error("undervoltage trip missing");

  a_force_no_trip: assert property (
    st_q == dcv_pkg::DCV_FAIL && force_restart_en ##1 force_restart_en
    |-> !tripped)
    else $error("forced restart tripped");

  a_readout_update: assert property (
    sample_valid |=> link_voltage_readout == $past(link_voltage))
    else $error("readout not updated");

  a_relay_close: assert property (
    sample_valid && link_voltage > close_lim |=> relay_closed)
    else $error("charging relay not closed");

  a_clear_state: assert property (
    st_q != dcv_pkg::DCV_FAIL |=> rs_ms_q == 14'h0000 || restart_warn)
    else $error("restart state not cleared");

  c_ride_through: cover property (
    st_q == dcv_pkg::DCV_RUN ##1 st_q == dcv_pkg::DCV_RIDE);
  c_restart_ok: cover property (
    st_q == dcv_pkg::DCV_FAIL ##1 st_q == dcv_pkg::DCV_RUN);
  c_restart_trip: cover property (
    st_q == dcv_pkg::DCV_FAIL ##1 tripped && fault_code == `DCV_FC_UV);
  c_standby_done: cover property (
    standby ##1 st_q == dcv_pkg::DCV_RUN);
endmodule : dcv_sup

// [dv/dcv_plant.sv]
// link voltage source model standing in for the power stage and supply
`timescale 1ns/1ps
module dcv_plant (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // requested link level
  input wire dcv_pkg::dcv_volt_t target,
  // sampled link
  output dcv_pkg::dcv_volt_t link_voltage,
  output logic sample_valid
);
  logic phase_q;
  // sample every second cycle; inverted level between samples
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      phase_q <= 1'b0;
      sample_valid <= 1'b0;
      link_voltage <= '0;
    end
    else
    begin
      phase_q <= ~phase_q;
      sample_valid <= phase_q;
      link_voltage <= phase_q ? target : ~target;
    end
  end
endmodule : dcv_plant

// [dv/test_dcv_sup.sv]
// self-checking bench for the link voltage supervisor
`timescale 1ns/1ps
module test_dcv_sup;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  dcv_pkg::dcv_volt_t target = 11'h258;
  dcv_pkg::dcv_volt_t link_voltage, link_voltage_readout;
  dcv_pkg::dcv_ac_t est_supply, range_low;
  logic sample_valid, start_cmd, generating, scalar_mode, fault_reset, ovc_en, uvc_en;
  logic auto_restart_en, force_restart_en, vec_start_auto, scalar_start_auto;
  logic range_auto, adaptive_en, ov_warn, uv_warn, restart_warn, tripped;
  logic gen_torque_limit, decel_stretch, chopper_on, relay_closed, modulation_en;
  logic fan_en, precharge_en, ride_through, standby, flying_start_ok, chop;
  logic [15:0] decel_time;
  logic [15:0] fault_code;
  logic [16:0] decel_time_eff;
  logic [13:0] restart_time_ms;
  int error_cnt = 0;
  int checks_done = 0;
  int seed;
  int v;
  int uvt[5][3] = '{'{0, 0, 454}, '{0, 0, 455}, '{1, 0, 520}, '{1, 1, 520}, '{1, 1, 527}};
  int corner[5] = '{780, 770, 760, 759, 745};

  dcv_plant dcv_plant_inst (.mclk, .nrst, .target, .link_voltage, .sample_valid);

  dcv_sup #(.MS_CYCLES(4)) dcv_sup_inst (
    .mclk, .nrst, .link_voltage, .sample_valid, .start_cmd, .generating, .scalar_mode,
    .decel_time, .fault_reset, .ovc_en, .uvc_en, .auto_restart_en, .force_restart_en,
    .vec_start_auto, .scalar_start_auto, .range_auto, .adaptive_en, .est_supply,
    .range_low, .restart_time_ms, .link_voltage_readout, .ov_warn, .uv_warn,
    .restart_warn, .fault_code, .tripped, .gen_torque_limit, .decel_stretch,
    .decel_time_eff, .chopper_on, .relay_closed, .modulation_en, .fan_en,
    .precharge_en, .ride_through, .standby, .flying_start_ok
  );

  always #2.5 mclk = ~mclk;

  function automatic int lim(input int base, input int k);
    return (base * k) >> 10;
  endfunction : lim

  task automatic chk(input logic [16:0] seen, input int exp);
    checks_done++;
    if (seen !== 17'(exp))
    begin
      error_cnt++;
      $display("mismatch at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask : chk

  task automatic complete_run;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : complete_run

  // new link level, then long enough for two samples and the state change
  task automatic set_v(input int lv);
    @(posedge mclk);
    target <= 11'(lv);
    repeat (8) @(posedge mclk);
    #1;
  endtask : set_v

  task automatic clear_trip;
    set_v(600);
    @(posedge mclk);
    fault_reset <= 1'b1;
    repeat (2) @(posedge mclk);
    fault_reset <= 1'b0;
    repeat (3) @(posedge mclk);
    #1;
    chk(tripped, 0);
    chk(fault_code, 0);
    chk(modulation_en, 1);
  endtask : clear_trip

  initial
  begin
    repeat (50000) @(posedge mclk);
    error_cnt++;
    complete_run();
  end

  initial
  begin
    seed = 10;
    {start_cmd, ovc_en, vec_start_auto} = 3'h7;
    {generating, scalar_mode, fault_reset, uvc_en, auto_restart_en} = 5'h00;
    {force_restart_en, scalar_start_auto, range_auto, adaptive_en, chop} = 5'h00;
    decel_time = 16'h0064;
    est_supply = 10'h1b8;
    range_low = 10'h17c;
    restart_time_ms = 14'h0002;
    repeat (4) @(posedge mclk);
    nrst <= 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    chk(modulation_en, 1);
    chk(fault_code, 0);
    for (int i = 0; i < 8; i++)
    begin
      @(posedge mclk);
      {scalar_mode, vec_start_auto, scalar_start_auto} <= 3'(i);
      #1;
      chk(flying_start_ok, (i > 3) ? (i % 2) : ((i / 2) % 2));
    end
    @(posedge mclk);
    scalar_mode <= 1'b0;
    vec_start_auto <= 1'b1;
    for (int i = 0; i < 30; i++)
    begin
      v = (i < 5) ? corner[i] : 600 + ($unsigned($random(seed)) % 240);
      @(posedge mclk);
      generating <= 1'($random(seed));
      decel_time <= 16'($random(seed));
      ovc_en <= (i < 5) ? 1'b1 : 1'($random(seed));
      set_v(v);
      chop = (v >= 780) ? 1'b1 : ((v < 760) ? 1'b0 : chop);
      chk(link_voltage_readout, v);
      chk(ov_warn, v >= 745);
      chk(chopper_on, chop);
      chk(gen_torque_limit, ovc_en && generating && v >= 780);
      chk(decel_stretch, ovc_en && v >= 780);
      chk(decel_time_eff, (ovc_en && v >= 780) ? (decel_time * 3) / 2 : decel_time);
    end
    foreach (uvt[i])
    begin
      @(posedge mclk);
      ovc_en <= 1'b1;
      range_auto <= 1'(uvt[i][0]);
      adaptive_en <= 1'(uvt[i][1]);
      set_v(uvt[i][2]);
      chk(uv_warn, uvt[i][2] < lim((uvt[i][0] && uvt[i][1]) ? 440 : 380, 1227));
    end
    @(posedge mclk);
    range_auto <= 1'b0;
    auto_restart_en <= 1'b1;
    restart_time_ms <= 14'h3fff;
    set_v(380);
    chk(restart_warn, 1);
    chk(tripped, 0);
    chk(modulation_en, 0);
    chk(fan_en, 0);
    chk(precharge_en, 1);
    chk(relay_closed, 0);
    repeat (39980) @(posedge mclk);
    #1;
    chk(tripped, 0);
    repeat (40) @(posedge mclk);
    #1;
    chk(tripped, 1);
    chk(fault_code, 16'h0c94);
    chk(restart_warn, 0);
    clear_trip();
    @(posedge mclk);
    restart_time_ms <= 14'h0064;
    start_cmd <= 1'b0;
    set_v(380);
    set_v(430);
    chk(modulation_en, 0);
    chk(relay_closed, 1);
    @(posedge mclk);
    start_cmd <= 1'b1;
    set_v(430);
    chk(modulation_en, 1);
    chk(restart_warn, 0);
    @(posedge mclk);
    {auto_restart_en, force_restart_en, start_cmd} <= 3'h2;
    restart_time_ms <= 14'h0001;
    set_v(380);
    repeat (20) @(posedge mclk);
    #1;
    chk(tripped, 0);
    chk(restart_warn, 1);
    set_v(430);
    chk(modulation_en, 1);
    @(posedge mclk);
    {force_restart_en, start_cmd} <= 2'h1;
    set_v(380);
    chk(standby, 1);
    chk(precharge_en, 1);
    chk(modulation_en, 0);
    set_v(430);
    chk(standby, 0);
    chk(modulation_en, 1);
    @(posedge mclk);
    uvc_en <= 1'b1;
    set_v(395);
    chk(ride_through, 1);
    chk(modulation_en, 1);
    set_v(460);
    chk(ride_through, 0);
    @(posedge mclk);
    uvc_en <= 1'b0;
    set_v(845);
    chk(tripped, 1);
    chk(fault_code, 16'h0001);
    clear_trip();
    complete_run();
  end
endmodule : test_dcv_sup
